// [rtl/timer_channel_params.svh]
// constants for the four-channel capture/compare block
// assumes inclusion by the package and the design module
`ifndef TIMER_CHANNEL_PARAMS_SVH
`define TIMER_CHANNEL_PARAMS_SVH
`define NUM_CHANNELS 4
`define CTL_ON_BIT 7
`define CTL_LEVEL_BIT 6
`define CTL_IRQ_BIT 5
`define CTL_IMM_BIT 4
`define CTL_RSVD_BIT 3
`define CTL_RESET 8'h00
`define FLAGS_RESET 8'h00
`define CMP_RESET 16'h0000
`define DIR_MODULO 2'h0
`define DIR_UPDOWN 2'h2
`endif

// [rtl/timer_channel_pkg.sv]
// types for the four-channel capture/compare block
// assumes the params header sits beside it
`include "timer_channel_params.svh"
package timer_channel_pkg;
    typedef enum logic [2:0] {
        OP_ONE_SHOT = 3'b000,
        OP_CONTINUOUS = 3'b001,
        OP_PWM = 3'b010,
        OP_CAPTURE = 3'b011
    } channel_operating_method_type;
endpackage

// [rtl/timer_channel_control_status.sv]
// channel control, compare, capture and event flag logic of a four-channel 16-bit timer
// assumes counter, reload and register access decode are provided by the surrounding timer
// assumes matches are qualified by the shared count tick, one tick per new count
// clock enable low freezes every register and drops the irq pulse for that cycle
// Operation
// - per-channel event flag set on any event
// - writing one clears flag, zero keeps
// - flags set regardless of interrupt enable
// - timer off holds all flags cleared
// - control bit 7 enables channel; reset zero
// - compare modes disabled drive polarity level
// - one-shot inverts output one clock on match
// - continuous mode toggles and holds on match
// - disabled pwm drives output low
// - pwm high on up-count match, low at reload (modulo) or on down-count match (up/down)
// - capture edge chosen by polarity bit
// - interrupt bit gates channel interrupt request
// - buffered compare writes apply at cycle end
// - update bit one applies writes immediately
// - timer off applies compare writes immediately
// - three-bit field selects mode; 100-111 reserved
// - counter modulo or up/down per mode
// - overrun flag on event while flag set
// - capture copies counter into compare bytes
`timescale 1ns/1ps
`include "timer_channel_params.svh"
module timer_channel_control_status
    import timer_channel_pkg::*;
(
    // clock, reset, enable
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    // shared timer state
    input wire logic timer_run_i,
    input wire logic [1:0] counter_direction_select_i,
    input wire logic [15:0] count_i,
    input wire logic [15:0] reload_i,
    input wire logic count_tick_i,
    input wire logic counting_down_i,
    input wire logic end_of_cycle_i,
    // register writes, channel selected by index except the flag write, which clears by one data bit per channel
    input wire logic [1:0] chan_sel_i,
    input wire logic channel_control_wr_i,
    input wire logic compare_high_byte_wr_i,
    input wire logic compare_low_byte_wr_i,
    input wire logic channel_event_flags_wr_i,
    input wire logic [7:0] wdata_i,
    // channel pins
    input wire logic [3:0] chan_in_i,
    output logic [3:0] chan_out_o,
    // register read views
    output logic [31:0] channel_control_o,
    output logic [63:0] compare_value_o,
    output logic [7:0] channel_event_flags_o,
    output logic [7:0] event_overrun_o,
    // interrupt request
    output logic channel_irq_o
);

    // --------------------------------------------------------------
    // per-channel state
    // --------------------------------------------------------------
    // control and compare, active and buffered
    logic [7:0] ctl_r [4];
    logic [7:0] ctl_nxt [4];
    logic [15:0] cmp_r [4];
    logic [15:0] cmp_nxt [4];
    logic [15:0] buf_r [4];
    logic [15:0] buf_nxt [4];
    logic [3:0] pend_r;
    logic [3:0] pend_nxt;

    // pin side
    logic [3:0] out_r;
    logic [3:0] out_nxt;
    logic [3:0] in_r;

    // event flags and overrun
    logic [3:0] flag_r;
    logic [3:0] flag_nxt;
    logic [3:0] ovr_r;
    logic [3:0] ovr_nxt;
    logic [3:0] event_w;

    // merged interrupt request
    logic irq_nxt;

    // --------------------------------------------------------------
    // channel logic
    // --------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `NUM_CHANNELS; g++) begin : gen_chan
            // decoded control fields
            logic on;
            logic level;
            logic imm;
            channel_operating_method_type op;
            // qualifiers
            logic sel;
            logic match;
            logic cap_edge;
            logic cap_hit;
            logic cmp_wr;
            logic pwm_set;
            logic pwm_clr_mod;
            logic pwm_clr_ud;

            assign on = ctl_r[g][`CTL_ON_BIT];
            assign level = ctl_r[g][`CTL_LEVEL_BIT];
            assign imm = ctl_r[g][`CTL_IMM_BIT];
            // codes past capture match no enum item and fall to the default branch
            assign op = channel_operating_method_type'(ctl_r[g][2:0]);
            assign sel = (chan_sel_i == 2'(g));
            // a match needs a fresh count, so a stalled counter fires only once
            assign match = timer_run_i && count_tick_i && (count_i == cmp_r[g]);
            // polarity zero picks rising edge, one picks falling
            assign cap_edge = (chan_in_i[g] != in_r[g]) && (chan_in_i[g] != level);
            // capture is refused while the channel is off or the timer is stopped
            assign cap_hit = on && timer_run_i && cap_edge;
            // both byte strobes share one buffer path; the low byte wins if both fire
            assign cmp_wr = (compare_high_byte_wr_i || compare_low_byte_wr_i) && sel;
            // pwm rises only while counting up; in up/down mode the down pass through the value drops it
            assign pwm_set = match && !counting_down_i;
            assign pwm_clr_mod = timer_run_i && count_tick_i && (counter_direction_select_i == `DIR_MODULO)
                                 && (count_i == reload_i);
            assign pwm_clr_ud = match && counting_down_i && (counter_direction_select_i == `DIR_UPDOWN);

            // ----------------------------------------------------------
            // compare buffer, output mode and events
            // ----------------------------------------------------------

            always_comb begin
                logic [15:0] wval;
                wval = buf_r[g];
                ctl_nxt[g] = ctl_r[g];
                cmp_nxt[g] = cmp_r[g];
                buf_nxt[g] = buf_r[g];
                pend_nxt[g] = pend_r[g];
                out_nxt[g] = out_r[g];
                event_w[g] = 1'b0;
                if (channel_control_wr_i && sel) begin
                    // reserved bit 3 reads zero
                    ctl_nxt[g] = wdata_i & ~(8'h01 << `CTL_RSVD_BIT);
                end
                if (compare_high_byte_wr_i && sel) begin
                    wval = {wdata_i, buf_r[g][7:0]};
                end
                if (compare_low_byte_wr_i && sel) begin
                    wval = {buf_r[g][15:8], wdata_i};
                end
                // a stop flushes a pending write so it is never lost
                if (cmp_wr) begin
                    buf_nxt[g] = wval;
                    if (!timer_run_i || imm) begin
                        cmp_nxt[g] = wval;
                        pend_nxt[g] = 1'b0;
                    end else begin
                        pend_nxt[g] = 1'b1;
                    end
                end else if (pend_r[g] && (end_of_cycle_i || !timer_run_i)) begin
                    cmp_nxt[g] = buf_r[g];
                    pend_nxt[g] = 1'b0;
                end
                // codes 100 to 111 are reserved; they hold the output low and raise no event
                case (op)
                    OP_ONE_SHOT: begin
                        out_nxt[g] = level;
                        if (on && match) begin
                            out_nxt[g] = ~level;
                            event_w[g] = 1'b1;
                        end
                    end
                    OP_CONTINUOUS: begin
                        if (!on) begin
                            out_nxt[g] = level;
                        end else if (match) begin
                            out_nxt[g] = ~out_r[g];
                            event_w[g] = 1'b1;
                        end
                    end
                    OP_PWM: begin
                        if (!on) begin
                            out_nxt[g] = 1'b0;
                        end else if (pwm_set) begin
                            out_nxt[g] = 1'b1;
                            event_w[g] = 1'b1;
                        end else if (pwm_clr_mod) begin
                            // reaching reload is not an event, only the level drops
                            out_nxt[g] = 1'b0;
                        end else if (pwm_clr_ud) begin
                            out_nxt[g] = 1'b0;
                            event_w[g] = 1'b1;
                        end
                    end
                    OP_CAPTURE: begin
                        out_nxt[g] = 1'b0;
                        if (cap_hit) begin
                            cmp_nxt[g] = count_i;
                            // buffer follows, so a stale buffered write cannot land later
                            buf_nxt[g] = count_i;
                            pend_nxt[g] = 1'b0;
                            event_w[g] = 1'b1;
                        end
                    end
                    default: begin
                        out_nxt[g] = 1'b0;
                    end
                endcase
            end

            // ----------------------------------------------------------
            // event and overrun flags
            // ----------------------------------------------------------
            always_comb begin
                flag_nxt[g] = flag_r[g];
                ovr_nxt[g] = ovr_r[g];
                if (channel_event_flags_wr_i && wdata_i[g]) begin
                    flag_nxt[g] = 1'b0;
                    ovr_nxt[g] = 1'b0;
                end
                // a new event in the clearing cycle still sets the flag
                if (event_w[g]) begin
                    flag_nxt[g] = 1'b1;
                    if (flag_r[g]) begin
                        ovr_nxt[g] = 1'b1;
                    end
                end
                // a stopped timer overrides both set and clear
                if (!timer_run_i) begin
                    flag_nxt[g] = 1'b0;
                    ovr_nxt[g] = 1'b0;
                end
            end

            // ----------------------------------------------------------
            // state registers
            // ----------------------------------------------------------
            always_ff @(posedge sys_clk_i) begin
                if (sys_rst_i) begin
                    ctl_r[g] <= `CTL_RESET;
                    cmp_r[g] <= `CMP_RESET;
                    buf_r[g] <= `CMP_RESET;
                    pend_r[g] <= 1'b0;
                    out_r[g] <= 1'b0;
                    // idle pin level is low, so no false edge follows reset
                    in_r[g] <= 1'b0;
                    flag_r[g] <= 1'b0;
                    ovr_r[g] <= 1'b0;
                end else if (clk_en_i) begin
                    ctl_r[g] <= ctl_nxt[g];
                    cmp_r[g] <= cmp_nxt[g];
                    buf_r[g] <= buf_nxt[g];
                    pend_r[g] <= pend_nxt[g];
                    out_r[g] <= out_nxt[g];
                    in_r[g] <= chan_in_i[g];
                    flag_r[g] <= flag_nxt[g];
                    ovr_r[g] <= ovr_nxt[g];
                end
            end

            // ----------------------------------------------------------
            // read views, registered from the next values
            // ----------------------------------------------------------
            always_ff @(posedge sys_clk_i) begin
                if (sys_rst_i) begin
                    chan_out_o[g] <= 1'b0;
                    channel_control_o[8*g +: 8] <= `CTL_RESET;
                    compare_value_o[16*g +: 16] <= `CMP_RESET;
                end else if (clk_en_i) begin
                    chan_out_o[g] <= out_nxt[g];
                    channel_control_o[8*g +: 8] <= ctl_nxt[g];
                    compare_value_o[16*g +: 16] <= cmp_nxt[g];
                end
            end
        end
    endgenerate

    // --------------------------------------------------------------
    // shared status and interrupt
    // --------------------------------------------------------------
    // one request per cycle however many channels fire
    always_comb begin
        irq_nxt = 1'b0;
        for (int i = 0; i < `NUM_CHANNELS; i++) begin
            if (event_w[i] && ctl_r[i][`CTL_IRQ_BIT]) begin
                irq_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            channel_event_flags_o <= `FLAGS_RESET;
            event_overrun_o <= `FLAGS_RESET;
            channel_irq_o <= 1'b0;
        end else if (clk_en_i) begin
            channel_event_flags_o <= {4'h0, flag_nxt};
            event_overrun_o <= {4'h0, ovr_nxt};
            channel_irq_o <= irq_nxt;
        end else begin
            // a frozen cycle must not repeat the pulse
            channel_irq_o <= 1'b0;
        end
    end

endmodule

// [test/timer_channel_monitor.sv]
// port assertions for the four-channel capture/compare block
// assumes binding onto the block, one clock, sync reset
`timescale 1ns/1ps
module timer_channel_monitor (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // inputs watched
    input wire logic clk_en_i,
    input wire logic timer_run_i,
    input wire logic end_of_cycle_i,
    input wire logic [1:0] chan_sel_i,
    input wire logic channel_control_wr_i,
    input wire logic compare_low_byte_wr_i,
    input wire logic channel_event_flags_wr_i,
    input wire logic [7:0] wdata_i,
    // outputs watched
    input wire logic [3:0] chan_out_o,
    input wire logic [31:0] channel_control_o,
    input wire logic [63:0] compare_value_o,
    input wire logic [7:0] channel_event_flags_o,
    input wire logic [7:0] event_overrun_o,
    input wire logic channel_irq_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    wire [7:0] c0 = channel_control_o[7:0];
    wire [7:0] c1 = channel_control_o[15:8];
    wire [7:0] c2 = channel_control_o[23:16];
    wire [3:0] irq_en = {channel_control_o[29], channel_control_o[21], channel_control_o[13], channel_control_o[5]};
    wire [7:0] csel = channel_control_o[{chan_sel_i, 3'h0} +: 8];
    wire [15:0] cmp_sel = compare_value_o[{chan_sel_i, 4'h0} +: 16];
    a_run_off_clear: assert property ((!timer_run_i && clk_en_i) |=>
        channel_event_flags_o[3:0] == 4'h0 && event_overrun_o[3:0] == 4'h0) else $error("flags kept while stopped");
    a_flag_no_drop: assert property ((!channel_event_flags_wr_i && timer_run_i) |=>
        (channel_event_flags_o[3:0] & $past(channel_event_flags_o[3:0])) == $past(channel_event_flags_o[3:0]))
        else $error("flag dropped without clear");
    a_irq_has_cause: assert property (channel_irq_o |->
        (channel_event_flags_o[3:0] & $past(irq_en)) != 4'h0) else $error("irq without enabled event");
    a_one_shot_pulse: assert property ((c1[7] && c1[2:0] == 3'b000 && chan_out_o[1] != c1[6] && clk_en_i
        && !channel_control_wr_i) |=> chan_out_o[1] == c1[6]) else $error("one-shot pulse too long");
    a_off_level: assert property (($stable(c0) && $past(clk_en_i) && !c0[7] && c0[2:1] == 2'b00)
        |-> chan_out_o[0] == c0[6]) else $error("disabled compare level wrong");
    a_pwm_off_low: assert property (($stable(c2) && $past(clk_en_i) && !c2[7] && c2[2:0] == 3'b010)
        |-> !chan_out_o[2]) else $error("disabled pwm not low");
    a_cmp_immediate: assert property ((compare_low_byte_wr_i && clk_en_i && (csel[4] || !timer_run_i)
        && csel[2:0] != 3'b011) |=> compare_value_o[{$past(chan_sel_i), 4'h0} +: 8] == $past(wdata_i))
        else $error("immediate compare write lost");
    a_cmp_buffered: assert property ((compare_low_byte_wr_i && clk_en_i && timer_run_i && !csel[4]
        && !end_of_cycle_i && csel[2:0] != 3'b011)
        |=> compare_value_o[{$past(chan_sel_i), 4'h0} +: 16] == $past(cmp_sel)) else $error("buffer bypassed");
    cover property (channel_irq_o);
    cover property (event_overrun_o[0]);
    cover property ($rose(channel_event_flags_o[3]));
endmodule
bind timer_channel_control_status timer_channel_monitor mon (.*);

// [test/chan_pins_model.sv]
// external pin partner: drives channel inputs, sees outputs
// assumes the bench calls set_pin between clock edges
`timescale 1ns/1ps
module chan_pins_model (
    input wire logic sys_clk_i,
    input wire logic [3:0] chan_out_i,
    output logic [3:0] chan_in_o
);
    initial chan_in_o = 4'h0;
    // pins change at the falling edge only, never at sampling
    task automatic set_pin(input int ch, input logic lvl);
        @(negedge sys_clk_i);
        chan_in_o[ch] = lvl;
    endtask
    // level seen at the pin, as the far side would see it
    function automatic logic pin_level(input int ch);
        return chan_out_i[ch];
    endfunction
endmodule

// [test/test_timer_channel_control_status.sv]
// directed bench for the four-channel capture/compare block
// assumes fixed latencies of the hand-over, inputs set at falling edge
`timescale 1ns/1ps
module test_timer_channel_control_status;
    import timer_channel_pkg::*;
    localparam logic [3:0] CTL = 4'h8, HI = 4'h4, LO = 4'h2, FLG = 4'h1;
    logic sys_clk_i = 0, sys_rst_i = 1, clk_en_i = 1, timer_run_i = 0, count_tick_i = 0;
    logic counting_down_i = 0, end_of_cycle_i = 0, channel_control_wr_i = 0, compare_high_byte_wr_i = 0;
    logic compare_low_byte_wr_i = 0, channel_event_flags_wr_i = 0, channel_irq_o;
    logic [1:0] counter_direction_select_i = 2'h0, chan_sel_i = 2'h0;
    logic [15:0] count_i = 16'h0000, reload_i = 16'h0040;
    logic [7:0] wdata_i = 8'h00, channel_event_flags_o, event_overrun_o;
    logic [3:0] chan_in_i, chan_out_o;
    logic [31:0] channel_control_o;
    logic [63:0] compare_value_o;
    int n_tests = 0, miscompares = 0;
    timer_channel_control_status uut (.*);
    chan_pins_model pins (.sys_clk_i(sys_clk_i), .chan_out_i(chan_out_o), .chan_in_o(chan_in_i));
    initial begin
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] which, input logic [1:0] ch, input logic [7:0] d);
        @(negedge sys_clk_i);
        {channel_control_wr_i, compare_high_byte_wr_i, compare_low_byte_wr_i, channel_event_flags_wr_i} = which;
        chan_sel_i = ch;
        wdata_i = d;
        @(negedge sys_clk_i);
        {channel_control_wr_i, compare_high_byte_wr_i, compare_low_byte_wr_i, channel_event_flags_wr_i} = 4'h0;
    endtask
    task automatic tick(input logic [15:0] cnt);
        @(negedge sys_clk_i);
        count_i = cnt;
        count_tick_i = 1;
        @(negedge sys_clk_i);
        count_tick_i = 0;
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (5000) @(posedge sys_clk_i);
        miscompares++;
        print_verdict();
    end
    initial begin
        repeat (12) @(negedge sys_clk_i);
        sys_rst_i = 0;
        chk(channel_control_o[15:0], 16'h0000);
        chk(channel_event_flags_o, 16'h0000);
        wr(LO, 0, 8'h10);
        chk(compare_value_o[15:0], 16'h0010);
        wr(CTL, 0, 8'h41);
        @(negedge sys_clk_i);
        chk(chan_out_o[0], 16'h0001);
        wr(CTL, 0, 8'hc1);
        timer_run_i = 1;
        tick(16'h0010);
        chk(chan_out_o[0], 16'h0000);
        chk(channel_event_flags_o, 16'h0001);
        chk(channel_irq_o, 16'h0000);
        tick(16'h0010);
        chk(chan_out_o[0], 16'h0001);
        chk(event_overrun_o, 16'h0001);
        wr(FLG, 0, 8'h0e);
        chk(channel_event_flags_o, 16'h0001);
        wr(FLG, 0, 8'h01);
        chk(channel_event_flags_o, 16'h0000);
        chk(event_overrun_o, 16'h0000);
        wr(CTL, 1, 8'ha0);
        wr(LO, 1, 8'h20);
        chk(compare_value_o[31:16], 16'h0000);
        @(negedge sys_clk_i);
        end_of_cycle_i = 1;
        @(negedge sys_clk_i);
        end_of_cycle_i = 0;
        chk(compare_value_o[31:16], 16'h0020);
        tick(16'h0020);
        chk(chan_out_o[1], 16'h0001);
        chk(channel_irq_o, 16'h0001);
        chk(channel_event_flags_o, 16'h0002);
        @(negedge sys_clk_i);
        chk(chan_out_o[1], 16'h0000);
        chk(channel_irq_o, 16'h0000);
        wr(CTL, 2, 8'hd2);
        wr(LO, 2, 8'h30);
        chk(compare_value_o[47:32], 16'h0030);
        tick(16'h0030);
        chk(chan_out_o[2], 16'h0001);
        tick(16'h0040);
        chk(chan_out_o[2], 16'h0000);
        tick(16'h0030);
        chk(chan_out_o[2], 16'h0001);
        wr(CTL, 2, 8'h52);
        @(negedge sys_clk_i);
        chk(chan_out_o[2], 16'h0000);
        chk(pins.pin_level(2), 16'h0000);
        counter_direction_select_i = 2'h2;
        wr(CTL, 2, 8'hd2);
        tick(16'h0030);
        chk(chan_out_o[2], 16'h0001);
        tick(16'h0040);
        chk(chan_out_o[2], 16'h0001);
        counting_down_i = 1;
        tick(16'h0030);
        chk(chan_out_o[2], 16'h0000);
        counting_down_i = 0;
        counter_direction_select_i = 2'h0;
        wr(CTL, 3, 8'h83);
        count_i = 16'h1234;
        pins.set_pin(3, 1'b1);
        @(negedge sys_clk_i);
        chk(compare_value_o[63:48], 16'h1234);
        chk(channel_event_flags_o[3], 16'h0001);
        wr(CTL, 3, 8'hc3);
        count_i = 16'h0055;
        pins.set_pin(3, 1'b0);
        @(negedge sys_clk_i);
        chk(compare_value_o[63:48], 16'h0055);
        timer_run_i = 0;
        @(negedge sys_clk_i);
        chk(channel_event_flags_o, 16'h0000);
        timer_run_i = 1;
        clk_en_i = 0;
        tick(16'h0010);
        clk_en_i = 1;
        chk(chan_out_o[0], 16'h0001);
        chk(channel_event_flags_o, 16'h0000);
        wr(CTL, 0, 8'h8c);
        chk(channel_control_o[7:0], 16'h0084);
        tick(16'h0010);
        @(negedge sys_clk_i);
        chk(channel_event_flags_o[0], 16'h0000);
        chk(chan_out_o[0], 16'h0000);
        wr(HI, 1, 8'h5a);
        chk(compare_value_o[31:16], 16'h0020);
        timer_run_i = 0;
        @(negedge sys_clk_i);
        chk(compare_value_o[31:16], 16'h5a20);
        print_verdict();
    end
endmodule
